// file: core/slot_map_defines.svh
`ifndef SLOT_MAP_DEFINES_SVH
`define SLOT_MAP_DEFINES_SVH

// ------------------------------------------------------------
// register offsets on the control port
// ------------------------------------------------------------
`define ADDR_SLOT2_ROUTE 8'h1f
`define ADDR_SLOT3_ROUTE 8'h20
`define ADDR_SLOT4_ROUTE 8'h21

// ------------------------------------------------------------
// reset values and writable-bit masks
// ------------------------------------------------------------
`define RESET_SLOT2_ROUTE 8'h01
`define RESET_SLOT3_ROUTE 8'h02
`define RESET_SLOT4_ROUTE 8'h03
`define WMASK_SLOT2 8'h3f
`define WMASK_SLOT34 8'h7f
`define UNMAPPED_READ 8'h00

// ------------------------------------------------------------
// field positions and source encodings
// ------------------------------------------------------------
`define SRC_BIT_LO 5
`define SRC_BIT_HI 6
`define SLOT_BIT_HI 4
`define SRC_HIZ 2'h0
`define SRC_REC 2'h1
`define SRC_MEAS 2'h2

// ------------------------------------------------------------
// frame timing counts in bit clocks
// ------------------------------------------------------------
`define I2S_STD_DELAY 6'h01
`define NO_STD_DELAY 6'h00
`define CNT_MAX 11'h7ff
`define LAST_BIT 5'h1f

`endif

// file: core/slot_map_pkg.sv
package slot_map_pkg;

    // framing formats of the serial port
    typedef enum logic [1:0] {
        fmt_tdm,
        fmt_i2s,
        fmt_lj
    } frame_fmt_t;

    // frame tracker states
    typedef enum logic {
        st_idle,
        st_run
    } track_state_t;

endpackage

// file: core/sync_2ff.sv
`timescale 1ns/10ps

// ------------------------------------------------------------
// two-flop synchroniser, one lane per bit
// ------------------------------------------------------------
module sync_2ff #(
    parameter int WIDTH = 2
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    // first stage feeds only the second
    for (genvar g = 0; g < WIDTH; g++) begin : g_bit
        always_ff @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
                stage1[g] <= 1'b0;
                sync_out[g] <= 1'b0;
            end else begin
                stage1[g] <= async_in[g];
                sync_out[g] <= stage1[g];
            end
        end
    end

endmodule

// file: core/chan_slot_lane.sv
`timescale 1ns/10ps
`include "slot_map_defines.svh"

// ------------------------------------------------------------
// one transmit channel: source pick, word latch, slot claim
// ------------------------------------------------------------
module chan_slot_lane (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic capture,
    input wire logic [1:0] source,
    input wire logic [4:0] slot_field,
    input wire logic is_tdm,
    input wire logic slot_valid,
    input wire logic half_right,
    input wire logic [4:0] cur_slot,
    input wire logic [31:0] rec_word,
    input wire logic [31:0] meas_word,
    input wire logic has_meas,
    output logic claim,
    output logic [31:0] word
);

    logic use_rec;
    logic use_meas;
    logic slot_hit;
    logic [31:0] next_word;

    // source decode; reserved codes behave as high impedance
    always_comb begin
        use_rec = (source == `SRC_REC);
        use_meas = has_meas && (source == `SRC_MEAS);
        if (is_tdm) begin
            slot_hit = (cur_slot == slot_field);
        end else begin
            slot_hit = !cur_slot[4] && (slot_field[4] == half_right)
                && (slot_field[3:0] == cur_slot[3:0]);
        end
        claim = slot_valid && (use_rec || use_meas) && slot_hit;
        next_word = word;
        if (capture) begin
            next_word = use_meas ? meas_word : rec_word;
        end
    end

    // word held for the whole frame
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            word <= 32'h0000_0000;
        end else begin
            word <= next_word;
        end
    end

endmodule

// file: core/aux_serial_tx_slot_mapper.sv
`timescale 1ns/10ps
`include "slot_map_defines.svh"

// Function
// - channel 2 source bit 5: 0 releases slot, 1 sends recorded channel 2.
// - channel 3 source bits 6-5: off, recorded 3, battery voltage, reserved.
// - channel 4 source bits 6-5: off, recorded 4, temperature, reserved.
// - tdm framing places each word in slot equal to bits 4-0, 0..31.
// - i2s/left-justified: values 0-15 left half, 16-31 right half slots.
// - channel 2 register resets to 0x01, off, slot 1.
// - channel 3 register resets to 0x02, off, slot 2.
// - channel 4 register resets to 0x03, off, slot 3.
// - channel 2 bits 7-6 read only zero; software writes zero there.
// - channel 3 and 4 bit 7 read only zero; software writes zero.
// - per-channel select routes slot data to primary or second output.
// - slot 0 msb delayed 0..31 bit clocks; all slots follow.

module aux_serial_tx_slot_mapper (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire slot_map_pkg::frame_fmt_t frame_fmt,
    input wire logic [4:0] msb_slot_delay,
    input wire logic chan2_pin_select,
    input wire logic chan3_pin_select,
    input wire logic chan4_pin_select,
    input wire logic bclk,
    input wire logic fsync,
    input wire logic [31:0] rec_ch2_word,
    input wire logic [31:0] rec_ch3_word,
    input wire logic [31:0] rec_ch4_word,
    input wire logic [31:0] vbat_word,
    input wire logic [31:0] temp_word,
    output logic serial_out,
    output logic serial_out_oe,
    output logic second_serial_out,
    output logic second_serial_out_oe
);

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    // register index from address, 3 when unmapped
    function automatic logic [1:0] reg_index(input logic [7:0] addr);
        logic [1:0] idx;
        idx = 2'h3;
        if (addr == `ADDR_SLOT2_ROUTE) begin
            idx = 2'h0;
        end else if (addr == `ADDR_SLOT3_ROUTE) begin
            idx = 2'h1;
        end else if (addr == `ADDR_SLOT4_ROUTE) begin
            idx = 2'h2;
        end
        return idx;
    endfunction

    // {enable, bit} for one pin; lowest channel wins a clash
    function automatic logic [1:0] pick_bit(input logic [2:0] claims,
        input logic [2:0][31:0] words, input logic [4:0] idx);
        logic [1:0] res;
        res = 2'h0;
        for (int i = 2; i >= 0; i--) begin
            if (claims[i]) begin
                res = {1'b1, words[i][`LAST_BIT - idx]};
            end
        end
        return res;
    endfunction

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [2:0][7:0] route;
    logic [2:0][7:0] next_route;
    logic [7:0] next_rdata;
    logic [1:0] acc_idx;

    // masked writes keep read-only bits at zero
    always_comb begin
        acc_idx = reg_index(reg_addr);
        next_route = route;
        next_rdata = reg_rdata;
        if (reg_wr && acc_idx != 2'h3) begin
            if (acc_idx == 2'h0) begin
                next_route[0] = reg_wdata & `WMASK_SLOT2;
            end else begin
                next_route[acc_idx] = reg_wdata & `WMASK_SLOT34;
            end
        end
        if (reg_rd) begin
            next_rdata = (acc_idx == 2'h3) ? `UNMAPPED_READ : route[acc_idx];
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            route[0] <= `RESET_SLOT2_ROUTE;
            route[1] <= `RESET_SLOT3_ROUTE;
            route[2] <= `RESET_SLOT4_ROUTE;
            reg_rdata <= 8'h00;
        end else begin
            route <= next_route;
            reg_rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // link sampling and edge detection
    // ------------------------------------------------------------
    logic [1:0] link_sync;
    logic bclk_q;
    logic bclk_rise;
    logic bclk_fall;
    logic fsync_s;

    sync_2ff #(
        .WIDTH(2)
    ) u_link_sync (
        .mclk(mclk),
        .rstn(rstn),
        .async_in({fsync, bclk}),
        .sync_out(link_sync)
    );

    assign fsync_s = link_sync[1];
    assign bclk_rise = link_sync[0] & ~bclk_q;
    assign bclk_fall = ~link_sync[0] & bclk_q;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            bclk_q <= 1'b0;
        end else begin
            bclk_q <= link_sync[0];
        end
    end

    // ------------------------------------------------------------
    // frame tracker
    // ------------------------------------------------------------
    slot_map_pkg::track_state_t state;
    slot_map_pkg::track_state_t next_state;
    logic [10:0] cnt;
    logic [10:0] next_cnt;
    logic half_right;
    logic next_half;
    logic fs_prev;
    logic next_fs_prev;
    logic frame_edge;
    logic capture;
    logic is_tdm;

    assign is_tdm = (frame_fmt == slot_map_pkg::fmt_tdm);

    // frame or half starts on fsync edges sampled at bclk rise
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_half = half_right;
        next_fs_prev = fs_prev;
        frame_edge = 1'b0;
        capture = 1'b0;
        if (bclk_rise) begin
            next_fs_prev = fsync_s;
            frame_edge = is_tdm ? (fsync_s & ~fs_prev) : (fsync_s ^ fs_prev);
        end
        case (state)
            slot_map_pkg::st_idle: begin
                if (frame_edge) begin
                    next_state = slot_map_pkg::st_run;
                end
            end
            slot_map_pkg::st_run: begin
                if (bclk_rise && !frame_edge && cnt != `CNT_MAX) begin
                    next_cnt = cnt + 11'h001;
                end
            end
            default: begin
                next_state = slot_map_pkg::st_idle;
            end
        endcase
        if (frame_edge) begin
            next_cnt = 11'h000;
            if (is_tdm) begin
                next_half = 1'b0;
            end else if (frame_fmt == slot_map_pkg::fmt_lj) begin
                next_half = ~fsync_s;
            end else begin
                next_half = fsync_s;
            end
            capture = !next_half;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state <= slot_map_pkg::st_idle;
            cnt <= 11'h000;
            half_right <= 1'b0;
            fs_prev <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            half_right <= next_half;
            fs_prev <= next_fs_prev;
        end
    end

    // ------------------------------------------------------------
    // slot position
    // ------------------------------------------------------------
    logic [5:0] delay;
    logic [10:0] pos;
    logic slot_valid;
    logic [4:0] cur_slot;
    logic [4:0] bit_idx;

    // standard delay plus programmable msb offset
    always_comb begin
        delay = ((frame_fmt == slot_map_pkg::fmt_i2s) ? `I2S_STD_DELAY : `NO_STD_DELAY)
            + {1'b0, msb_slot_delay};
        pos = cnt - {5'h00, delay};
        slot_valid = (state == slot_map_pkg::st_run) && (cnt >= {5'h00, delay})
            && (is_tdm ? !pos[10] : (pos[10:9] == 2'h0));
        cur_slot = pos[9:5];
        bit_idx = pos[4:0];
    end

    // ------------------------------------------------------------
    // channel lanes
    // ------------------------------------------------------------
    logic [2:0][31:0] rec_words;
    logic [2:0][31:0] meas_words;
    logic [2:0][31:0] lane_word;
    logic [2:0] claim;
    logic [2:0] pin_sel;

    assign rec_words = {rec_ch4_word, rec_ch3_word, rec_ch2_word};
    assign meas_words = {temp_word, vbat_word, 32'h0000_0000};
    assign pin_sel = {chan4_pin_select, chan3_pin_select, chan2_pin_select};

    // channel 2 has a single source bit, 3 and 4 a two-bit field
    for (genvar g = 0; g < 3; g++) begin : g_lane
        chan_slot_lane u_lane (
            .mclk(mclk),
            .rstn(rstn),
            .capture(capture),
            .source((g == 0) ? {1'b0, route[g][`SRC_BIT_LO]}
                : route[g][`SRC_BIT_HI:`SRC_BIT_LO]),
            .slot_field(route[g][`SLOT_BIT_HI:0]),
            .is_tdm(is_tdm),
            .slot_valid(slot_valid),
            .half_right(half_right),
            .cur_slot(cur_slot),
            .rec_word(rec_words[g]),
            .meas_word(meas_words[g]),
            .has_meas(g != 0),
            .claim(claim[g]),
            .word(lane_word[g])
        );
    end

    // ------------------------------------------------------------
    // output pins
    // ------------------------------------------------------------
    logic [1:0] drv0;
    logic [1:0] drv1;
    logic next_out;
    logic next_out_oe;
    logic next_out2;
    logic next_out2_oe;

    // launch on bclk fall; release when nothing claims the slot
    always_comb begin
        drv0 = pick_bit(claim & ~pin_sel, lane_word, bit_idx);
        drv1 = pick_bit(claim & pin_sel, lane_word, bit_idx);
        next_out = serial_out;
        next_out_oe = serial_out_oe;
        next_out2 = second_serial_out;
        next_out2_oe = second_serial_out_oe;
        if (bclk_fall) begin
            {next_out_oe, next_out} = drv0;
            {next_out2_oe, next_out2} = drv1;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            serial_out <= 1'b0;
            serial_out_oe <= 1'b0;
            second_serial_out <= 1'b0;
            second_serial_out_oe <= 1'b0;
        end else begin
            serial_out <= next_out;
            serial_out_oe <= next_out_oe;
            second_serial_out <= next_out2;
            second_serial_out_oe <= next_out2_oe;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_reset_routes: assert property (@(posedge mclk) $rose(rstn) |->
        route[0] == 8'h01 && route[1] == 8'h02 && route[2] == 8'h03)
        else $error("route registers not at reset values");

    a_slot2_rsvd_zero: assert property (@(posedge mclk) disable iff (!rstn)
        reg_wr && reg_addr == 8'h1f |=> route[0] == ($past(reg_wdata) & 8'h3f))
        else $error("channel 2 write did not mask bits 7-6");

    a_slot34_rsvd_zero: assert property (@(posedge mclk) disable iff (!rstn)
        reg_rd && reg_addr inside {8'h20, 8'h21} |=> !reg_rdata[7])
        else $error("channel 3/4 bit 7 read back set");

    a_tdm_slot_drive: assert property (@(posedge mclk) disable iff (!rstn)
        bclk_fall && is_tdm && slot_valid && route[0][5] && !chan2_pin_select
        && cur_slot == route[0][4:0]
        |=> serial_out_oe && serial_out == $past(lane_word[0][5'h1f - bit_idx]))
        else $error("tdm slot not driven with channel 2 bit");

    a_half_slot_drive: assert property (@(posedge mclk) disable iff (!rstn)
        bclk_fall && !is_tdm && slot_valid && !cur_slot[4]
        && route[1][6:5] inside {2'h1, 2'h2} && {half_right, cur_slot[3:0]} == route[1][4:0]
        |=> (chan3_pin_select ? second_serial_out_oe : serial_out_oe))
        else $error("left/right half slot not driven");

    a_reserved_src_off: assert property (@(posedge mclk) disable iff (!rstn)
        route[1][6:5] == 2'h3 |-> !claim[1])
        else $error("reserved channel 3 source claimed a slot");

    a_temp_capture: assert property (@(posedge mclk) disable iff (!rstn)
        capture && route[2][6:5] == 2'h2 |=> lane_word[2] == $past(temp_word))
        else $error("channel 4 did not capture temperature word");

    a_msb_offset_gap: assert property (@(posedge mclk) disable iff (!rstn)
        state == slot_map_pkg::st_run && cnt < {6'h00, msb_slot_delay} |-> !slot_valid)
        else $error("slot active before msb offset elapsed");

    a_pin_route: assert property (@(posedge mclk) disable iff (!rstn)
        bclk_fall && claim == 3'h1 && chan2_pin_select
        |=> second_serial_out_oe && !serial_out_oe)
        else $error("channel 2 not routed to second output");

    a_idle_release: assert property (@(posedge mclk) disable iff (!rstn)
        bclk_fall && (claim & ~pin_sel) == 3'h0 |=> !serial_out_oe)
        else $error("primary output driven in unclaimed slot");

    a_src_off_hiz: assert property (@(posedge mclk) disable iff (!rstn)
        !route[0][5] |-> !claim[0])
        else $error("channel 2 claimed a slot while off");

    c_tdm_drive: cover property (@(posedge mclk) disable iff (!rstn)
        is_tdm && serial_out_oe);
    c_right_half: cover property (@(posedge mclk) disable iff (!rstn)
        !is_tdm && half_right && |claim);
    c_second_pin: cover property (@(posedge mclk) disable iff (!rstn)
        second_serial_out_oe);

endmodule

// file: tb/serial_host.sv
`timescale 1ns/10ps

// ------------------------------------------------------------
// far-side receiver: makes bit clock and frame sync, samples both pins
// ------------------------------------------------------------
module serial_host (
    input wire logic serial_out,
    input wire logic serial_out_oe,
    input wire logic second_serial_out,
    input wire logic second_serial_out_oe,
    output logic bclk,
    output logic fsync
);
    logic [1:0] cap_oe [0:1055];
    logic [1:0] cap_d [0:1055];

    // bit clock stands still low between frames
    initial begin
        bclk = 1'b0;
        fsync = 1'b0;
    end

    // one frame: a lead cycle, then nb+1 bit clocks; bit k is sampled at rise k+1
    task automatic frame(input int fmt, input int half, input int nb);
        logic fs;
        for (int i = -1; i <= nb; i++) begin
            if (fmt == 0) begin
                fs = (i == 0);
            end else if (fmt == 1) begin
                fs = (i < 0) || (i >= half);
            end else begin
                fs = (i >= 0) && (i < half);
            end
            fsync = fs;
            #62.5 bclk = 1'b1;
            if (i >= 1) begin
                cap_oe[i-1] = {second_serial_out_oe, serial_out_oe};
                cap_d[i-1] = {second_serial_out, serial_out};
            end
            #62.5 bclk = 1'b0;
        end
    endtask
endmodule

// file: tb/test_aux_serial_tx_slot_mapper.sv
`timescale 1ns/10ps

module test_aux_serial_tx_slot_mapper;
    // ------------------------------------------------------------
    // stimulus, observed outputs and bench state
    // ------------------------------------------------------------
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    slot_map_pkg::frame_fmt_t frame_fmt = slot_map_pkg::fmt_tdm;
    logic [4:0] msb_slot_delay = 5'h00;
    logic chan2_pin_select = 1'b0;
    logic chan3_pin_select = 1'b0;
    logic chan4_pin_select = 1'b0;
    logic bclk;
    logic fsync;
    logic [31:0] rec_ch2_word = 32'h8c3a_51e7;
    logic [31:0] rec_ch3_word = 32'h1b6d_e290;
    logic [31:0] rec_ch4_word = 32'hc5f0_3a69;
    logic [31:0] vbat_word = 32'h5a96_0ff1;
    logic [31:0] temp_word = 32'he01d_7c34;
    logic serial_out;
    logic serial_out_oe;
    logic second_serial_out;
    logic second_serial_out_oe;
    int fail_count = 0;
    int num_checks = 0;
    int src_cfg [2:4];
    int slot_cfg [2:4];
    logic pin_cfg [2:4];

    // system clock, 10 ns
    always #5 mclk = ~mclk;

    aux_serial_tx_slot_mapper i_aux_serial_tx_slot_mapper (.mclk, .rstn, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .frame_fmt, .msb_slot_delay, .chan2_pin_select,
        .chan3_pin_select, .chan4_pin_select, .bclk, .fsync, .rec_ch2_word, .rec_ch3_word,
        .rec_ch4_word, .vbat_word, .temp_word, .serial_out, .serial_out_oe,
        .second_serial_out, .second_serial_out_oe);

    serial_host i_serial_host (.serial_out, .serial_out_oe, .second_serial_out,
        .second_serial_out_oe, .bclk, .fsync);

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s exp %h seen %h", name, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
        @(posedge mclk);
        reg_addr <= addr;
        reg_wdata <= data;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    // read data is registered and shows just after the taking edge; the task samples it one cycle later
    task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
        @(posedge mclk);
        reg_addr <= addr;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(posedge mclk);
        #1 data = reg_rdata;
    endtask

    function automatic logic [31:0] chan_word(input int ch);
        if (ch == 2) return rec_ch2_word;
        if (ch == 3) return (src_cfg[3] == 2) ? vbat_word : rec_ch3_word;
        return (src_cfg[4] == 2) ? temp_word : rec_ch4_word;
    endfunction

    // program one channel; reserved bits always written as zero
    task automatic set_chan(input int ch, input int src, input int slot, input logic pin);
        src_cfg[ch] = src;
        slot_cfg[ch] = slot;
        pin_cfg[ch] = pin;
        if (ch == 2) begin
            reg_write(8'h1f, {2'b00, src[0], slot[4:0]});
            chan2_pin_select <= pin;
        end else begin
            reg_write(8'h1d + ch[7:0], {1'b0, src[1:0], slot[4:0]});
            if (ch == 3) chan3_pin_select <= pin;
            else chan4_pin_select <= pin;
        end
    endtask

    // run one frame; check the enable at every sampled bit on both pins, the data bit only in claimed slots
    task automatic run_frame(input slot_map_pkg::frame_fmt_t fmt, input int half, input int nb,
            input int delay);
        int p;
        int d;
        int s;
        int r;
        int e_ch;
        logic [31:0] w;
        @(posedge mclk);
        frame_fmt <= fmt;
        msb_slot_delay <= delay[4:0];
        @(posedge mclk);
        i_serial_host.frame(int'(fmt), half, nb);
        d = delay + ((fmt == slot_map_pkg::fmt_i2s) ? 1 : 0);
        for (int k = 0; k < nb; k++) begin
            r = (fmt != slot_map_pkg::fmt_tdm && k >= half) ? 1 : 0;
            p = k - r * half;
            s = (p - d) / 32;
            for (int pin = 0; pin < 2; pin++) begin
                e_ch = 0;
                if (p >= d && s <= ((fmt == slot_map_pkg::fmt_tdm) ? 31 : 15)) begin
                    for (int ch = 4; ch >= 2; ch--) begin
                        if (src_cfg[ch] inside {1, 2} && int'(pin_cfg[ch]) == pin
                                && slot_cfg[ch] == s + 16 * r) begin
                            e_ch = ch;
                        end
                    end
                end
                check($sformatf("oe%0d_%0d", pin, k), {31'h0, i_serial_host.cap_oe[k][pin]},
                    {31'h0, e_ch != 0});
                if (e_ch != 0) begin
                    w = chan_word(e_ch);
                    check($sformatf("bit%0d_%0d", pin, k), {31'h0, i_serial_host.cap_d[k][pin]},
                        {31'h0, w[31 - (p - d) % 32]});
                end
            end
        end
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_reset_state();
        logic [7:0] d;
        reg_read(8'h1f, d);
        check("slot2 reset", {24'h0, d}, 32'h01);
        reg_read(8'h20, d);
        check("slot3 reset", {24'h0, d}, 32'h02);
        reg_read(8'h21, d);
        check("slot4 reset", {24'h0, d}, 32'h03);
        reg_read(8'h1e, d);
        check("unmapped read", {24'h0, d}, 32'h00);
        check("oe before frame", {30'h0, second_serial_out_oe, serial_out_oe}, 32'h0);
    endtask

    task automatic test_write_masks();
        logic [7:0] d;
        reg_write(8'h1f, 8'h3f);
        reg_read(8'h1f, d);
        check("slot2 mask", {24'h0, d}, 32'h3f);
        reg_write(8'h20, 8'h7f);
        reg_read(8'h20, d);
        check("slot3 mask", {24'h0, d}, 32'h7f);
        reg_write(8'h21, 8'h7f);
        reg_read(8'h21, d);
        check("slot4 mask", {24'h0, d}, 32'h7f);
        reg_write(8'h22, 8'hff);
        reg_read(8'h22, d);
        check("unmapped write", {24'h0, d}, 32'h00);
    endtask

    // full tdm frame, slots 0, 1 and 31, battery data on second pin
    task automatic test_tdm_basic();
        set_chan(2, 1, 0, 1'b0);
        set_chan(3, 2, 31, 1'b1);
        set_chan(4, 1, 1, 1'b0);
        run_frame(slot_map_pkg::fmt_tdm, 1024, 1024, 0);
    endtask

    // largest msb offset, off and reserved sources, temperature data
    task automatic test_tdm_offset();
        set_chan(2, 0, 0, 1'b0);
        set_chan(3, 3, 1, 1'b0);
        set_chan(4, 2, 2, 1'b1);
        run_frame(slot_map_pkg::fmt_tdm, 130, 130, 31);
    endtask

    // two channels on one slot and pin: the lower channel owns it
    task automatic test_tdm_conflict();
        set_chan(2, 1, 1, 1'b1);
        set_chan(3, 1, 1, 1'b1);
        set_chan(4, 3, 0, 1'b0);
        run_frame(slot_map_pkg::fmt_tdm, 100, 100, 3);
    endtask

    task automatic test_i2s_halves();
        set_chan(2, 1, 16, 1'b1);
        set_chan(3, 0, 0, 1'b0);
        set_chan(4, 2, 17, 1'b0);
        run_frame(slot_map_pkg::fmt_i2s, 72, 144, 0);
    endtask

    task automatic test_lj_halves();
        set_chan(2, 1, 16, 1'b0);
        set_chan(3, 2, 0, 1'b0);
        set_chan(4, 0, 15, 1'b1);
        run_frame(slot_map_pkg::fmt_lj, 40, 80, 2);
    endtask

    // main sequence
    initial begin
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        test_reset_state();
        test_write_masks();
        test_tdm_basic();
        test_tdm_offset();
        test_tdm_conflict();
        test_i2s_halves();
        test_lj_halves();
        report_and_stop();
    end

    // watchdog: about 1500 bit clocks of 125 ns plus register traffic
    initial begin
        #400000;
        fail_count++;
        report_and_stop();
    end
endmodule
